// [csl_map.vh]
// constants for the store, code read, shift and flag execution core
`ifndef CSL_MAP_VH
`define CSL_MAP_VH
// =====================================================================
// operation codes presented on opCode
`define CSL_OP_ST       5'h00
`define CSL_OP_STS      5'h01
`define CSL_OP_LPM      5'h02
`define CSL_OP_EXTENDED_CODE_BYTE_READ     5'h03
`define CSL_OP_SPM      5'h04
`define CSL_OP_IN       5'h05
`define CSL_OP_OUT      5'h06
`define CSL_OP_PUSH     5'h07
`define CSL_OP_POP      5'h08
`define CSL_OP_SBI      5'h09
`define CSL_OP_CBI      5'h0A
`define CSL_OP_LSL      5'h0B
`define CSL_OP_LSR      5'h0C
`define CSL_OP_ROL      5'h0D
`define CSL_OP_ROR      5'h0E
`define CSL_OP_ASR      5'h0F
`define CSL_OP_SWAP     5'h10
`define CSL_OP_FLAG_BY_INDEX_SET     5'h11
`define CSL_OP_FLAG_BY_INDEX_CLEAR     5'h12
`define CSL_OP_BST      5'h13
`define CSL_OP_BLD      5'h14
`define CSL_OP_SEC      5'h15
`define CSL_OP_CLC      5'h16
`define CSL_OP_SEN      5'h17
`define CSL_OP_CLN      5'h18
`define CSL_OP_SEZ      5'h19
`define CSL_OP_CLZ      5'h1A
`define CSL_OP_SEI      5'h1B
`define CSL_OP_CLI      5'h1C
// =====================================================================
// addressing modes on opMode
`define CSL_MODE_PLAIN  2'h0
`define CSL_MODE_POSTI  2'h1
`define CSL_MODE_PRED   2'h2
`define CSL_MODE_DISP   2'h3
// pointer select on opPtr and low register of each pair
`define CSL_PTR_X       2'h0
`define CSL_PTR_Y       2'h1
`define CSL_PTR_Z       2'h2
`define CSL_XL          5'h1A
`define CSL_YL          5'h1C
`define CSL_ZL          5'h1E
`define CSL_R0          5'h00
`define CSL_R1          5'h01
// =====================================================================
// flag register bit positions
`define CSL_F_C         3'h0
`define CSL_F_Z         3'h1
`define CSL_F_N         3'h2
`define CSL_F_V         3'h3
`define CSL_F_T         3'h6
`define CSL_F_I         3'h7
// =====================================================================
// register port map
`define CSL_A_RF_TOP    8'h1F
`define CSL_A_FLAGS     8'h20
`define CSL_A_PAGE      8'h21
`define CSL_A_SPL       8'h22
`define CSL_A_SPH       8'h23
`define CSL_A_STAT      8'h24
// reset values
`define CSL_SP_RESET    16'h0000
`define CSL_FLAGS_RESET 8'h00
`define CSL_PAGE_RESET  8'h00
`endif

// [csl_core.v]
// execution core for stores, code reads, stack, i/o bits, shifts and flags
// Behaviour
// - post-increment pointer store writes at X/Y/Z then bumps it, 2 cycles.
// - pre-decrement store lowers X/Y/Z first then writes there, 2 cycles.
// - displacement store writes at Y/Z plus q, pointer kept, 2 cycles.
// - direct data write stores the register at address k, 2 cycles, no flags.
// - code byte read loads byte at Z, optional Z bump, 3 cycles.
// - extended code read uses page:Z, increment carries into page, 3 cycles.
// - stack save and restore move one byte, 2 cycles, no flags.
// - i/o bit set forces bit b high, others kept, 2 cycles.
// - i/o bit clear forces bit b low, others kept, 2 cycles.
// - left logical shift, zero into bit 0, sets Z C N V, 1 cycle.
// - right logical shift, zero into bit 7, sets Z C N V, 1 cycle.
// - left rotate through carry, sets Z C N V, 1 cycle.
// - right rotate through carry, sets Z C N V, 1 cycle.
// - signed right shift keeps bit 7, sets Z C N V, 1 cycle.
// - bit b of a register copied to T, 1 cycle.
// - T copied into bit b of a register, 1 cycle, no flags.
// - single flag set or clear for C N Z I, 1 cycle.
//
// Our own choices: the plain strobed port and the register addresses.
`include "csl_map.vh"
module csl_core (
  input  wire        clk,
  input  wire        rst_n,
  // operation request
  input  wire        opStart,
  input  wire [4:0]  opCode,
  input  wire [4:0]  opReg,
  input  wire [1:0]  opPtr,
  input  wire [1:0]  opMode,
  input  wire [2:0]  opBit,
  input  wire [5:0]  opDisp,
  input  wire [15:0] opAddr,
  output wire        opReady,
  output reg         opDone,
  // data space
  output reg         dataWrEn,
  output reg  [15:0] dataWrAddr,
  output reg  [7:0]  dataWrData,
  output wire        dataRdEn,
  output wire [15:0] dataRdAddr,
  input  wire [7:0]  dataRdData,
  // i/o space
  output reg         ioWrEn,
  output reg  [5:0]  ioWrAddr,
  output reg  [7:0]  ioWrData,
  output wire        ioRdEn,
  output wire [5:0]  ioRdAddr,
  input  wire [7:0]  ioRdData,
  // program memory
  output reg         codeRdEn,
  output reg  [23:0] codeRdAddr,
  input  wire [7:0]  codeRdData,
  output reg         spmReq,
  output reg  [23:0] spmAddr,
  output reg  [15:0] spmData,
  input  wire        spmDone,
  // register port
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdData
);

  // =====================================================================
  // state
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_FIN   = 3'h1;
  localparam [2:0] S_CODE1 = 3'h2;
  localparam [2:0] S_CODE2 = 3'h3;
  localparam [2:0] S_SPMW  = 3'h4;

  reg [7:0]  rf [0:31];
  reg [7:0]  flagReg;
  reg [7:0]  codePage;
  reg [15:0] stackPtr;
  reg [2:0]  state;
  reg [4:0]  curReg;
  integer    i;

  // =====================================================================
  // helpers
  function [4:0] ptrLo;
    input [1:0] sel;
    begin
      case (sel)
        `CSL_PTR_X: ptrLo = `CSL_XL;
        `CSL_PTR_Y: ptrLo = `CSL_YL;
        default:    ptrLo = `CSL_ZL;
      endcase
    end
  endfunction

  function [15:0] ptrVal;
    input [1:0] sel;
    reg   [4:0] lo;
    begin
      lo = ptrLo(sel);
      ptrVal = {rf[lo + 5'h01], rf[lo]};
    end
  endfunction

  // flags of a shift: result and carry out give {V,N,Z,C}
  function [3:0] shiftFlags;
    input [7:0] res;
    input       cOut;
    begin
      shiftFlags = {res[7] ^ cOut, res[7], res == 8'h00, cOut};
    end
  endfunction

  wire        idle     = (state == S_IDLE);
  wire        take     = idle & opStart;
  wire [7:0]  src      = rf[opReg];
  wire [15:0] ptrNow   = ptrVal(opPtr);
  wire [15:0] zNow     = ptrVal(`CSL_PTR_Z);
  wire [23:0] extZ     = {codePage, zNow};
  wire [4:0]  pLo      = ptrLo(opPtr);
  wire [15:0] ptrMinus = ptrNow - 16'h0001;
  wire [15:0] ptrPlus  = ptrNow + 16'h0001;
  wire [15:0] spPlus   = stackPtr + 16'h0001;
  wire        cIn      = flagReg[`CSL_F_C];

  // =====================================================================
  // combinational read ports: memories answer in the same cycle
  assign opReady    = idle;
  assign dataRdEn   = take & (opCode == `CSL_OP_POP);
  assign dataRdAddr = spPlus;
  assign ioRdEn     = take & ((opCode == `CSL_OP_IN) | (opCode == `CSL_OP_SBI) | (opCode == `CSL_OP_CBI));
  assign ioRdAddr   = opAddr[5:0];

  // shifter results for the five shift forms
  reg [7:0] shRes;
  reg       shC;
  always @*
  begin
    case (opCode)
      `CSL_OP_LSL: begin shRes = {src[6:0], 1'b0};   shC = src[7]; end
      `CSL_OP_LSR: begin shRes = {1'b0, src[7:1]};   shC = src[0]; end
      `CSL_OP_ROL: begin shRes = {src[6:0], cIn};    shC = src[7]; end
      `CSL_OP_ROR: begin shRes = {cIn, src[7:1]};    shC = src[0]; end
      default:     begin shRes = {src[7], src[7:1]}; shC = src[0]; end
    endcase
  end
  wire [3:0] shF = shiftFlags(shRes, shC);

  // =====================================================================
  // sequencer, register file and flags in one process so each has one driver
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state      <= S_IDLE;
      flagReg    <= `CSL_FLAGS_RESET;
      codePage   <= `CSL_PAGE_RESET;
      stackPtr   <= `CSL_SP_RESET;
      curReg     <= `CSL_R0;
      opDone     <= 1'b0;
      dataWrEn   <= 1'b0;
      dataWrAddr <= 16'h0000;
      dataWrData <= 8'h00;
      ioWrEn     <= 1'b0;
      ioWrAddr   <= 6'h00;
      ioWrData   <= 8'h00;
      codeRdEn   <= 1'b0;
      codeRdAddr <= 24'h000000;
      spmReq     <= 1'b0;
      spmAddr    <= 24'h000000;
      spmData    <= 16'h0000;
      regRdData  <= 8'h00;
      for (i = 0; i < 32; i = i + 1)
        rf[i] <= 8'h00;
    end
    else
    begin
      // strobes last one cycle
      opDone   <= 1'b0;
      dataWrEn <= 1'b0;
      ioWrEn   <= 1'b0;
      codeRdEn <= 1'b0;
      spmReq   <= 1'b0;
      case (state)
        S_IDLE:
          if (opStart)
          begin
            curReg <= opReg;
            // single-cycle forms report completion in the next cycle
            opDone <= 1'b1;
            case (opCode)
              `CSL_OP_ST:
              begin
                dataWrEn   <= 1'b1;
                dataWrData <= src;
                opDone     <= 1'b0;
                state      <= S_FIN;
                case (opMode)
                  `CSL_MODE_POSTI:
                  begin
                    dataWrAddr    <= ptrNow;
                    rf[pLo]       <= ptrPlus[7:0];
                    rf[pLo+5'h01] <= ptrPlus[15:8];
                  end
                  `CSL_MODE_PRED:
                  begin
                    dataWrAddr    <= ptrMinus;
                    rf[pLo]       <= ptrMinus[7:0];
                    rf[pLo+5'h01] <= ptrMinus[15:8];
                  end
                  `CSL_MODE_DISP:
                    dataWrAddr <= ptrNow + {10'h000, opDisp};
                  default:
                    dataWrAddr <= ptrNow;
                endcase
              end
              `CSL_OP_STS:
              begin
                dataWrEn   <= 1'b1;
                dataWrAddr <= opAddr;
                dataWrData <= src;
                opDone     <= 1'b0;
                state      <= S_FIN;
              end
              `CSL_OP_LPM, `CSL_OP_EXTENDED_CODE_BYTE_READ:
              begin
                codeRdEn <= 1'b1;
                opDone   <= 1'b0;
                state    <= S_CODE1;
                if (opCode == `CSL_OP_EXTENDED_CODE_BYTE_READ)
                  codeRdAddr <= extZ;
                else
                  codeRdAddr <= {8'h00, zNow};
                if (opMode == `CSL_MODE_POSTI)
                begin
                  // the extended form carries the increment into the page
                  if (opCode == `CSL_OP_EXTENDED_CODE_BYTE_READ)
                    {codePage, rf[`CSL_ZL+5'h01], rf[`CSL_ZL]} <= extZ + 24'h000001;
                  else
                    {rf[`CSL_ZL+5'h01], rf[`CSL_ZL]} <= zNow + 16'h0001;
                end
              end
              `CSL_OP_SPM:
              begin
                spmReq  <= 1'b1;
                spmAddr <= extZ;
                spmData <= {rf[`CSL_R1], rf[`CSL_R0]};
                opDone  <= 1'b0;
                state   <= S_SPMW;
              end
              `CSL_OP_IN:
                rf[opReg] <= ioRdData;
              `CSL_OP_OUT:
              begin
                ioWrEn   <= 1'b1;
                ioWrAddr <= opAddr[5:0];
                ioWrData <= src;
              end
              `CSL_OP_PUSH:
              begin
                // stack grows downward: write then decrement
                dataWrEn   <= 1'b1;
                dataWrAddr <= stackPtr;
                dataWrData <= src;
                stackPtr   <= stackPtr - 16'h0001;
                opDone     <= 1'b0;
                state      <= S_FIN;
              end
              `CSL_OP_POP:
              begin
                rf[opReg] <= dataRdData;
                stackPtr  <= spPlus;
                opDone    <= 1'b0;
                state     <= S_FIN;
              end
              `CSL_OP_SBI, `CSL_OP_CBI:
              begin
                // read-modify-write keeps the neighbouring bits intact
                ioWrEn   <= 1'b1;
                ioWrAddr <= opAddr[5:0];
                if (opCode == `CSL_OP_SBI)
                  ioWrData <= ioRdData | (8'h01 << opBit);
                else
                  ioWrData <= ioRdData & ~(8'h01 << opBit);
                opDone   <= 1'b0;
                state    <= S_FIN;
              end
              `CSL_OP_LSL, `CSL_OP_LSR, `CSL_OP_ROL, `CSL_OP_ROR, `CSL_OP_ASR:
              begin
                rf[opReg] <= shRes;
                flagReg[`CSL_F_C] <= shF[0];
                flagReg[`CSL_F_Z] <= shF[1];
                flagReg[`CSL_F_N] <= shF[2];
                flagReg[`CSL_F_V] <= shF[3];
              end
              `CSL_OP_SWAP:
                rf[opReg] <= {src[3:0], src[7:4]};
              `CSL_OP_FLAG_BY_INDEX_SET:
                flagReg[opBit] <= 1'b1;
              `CSL_OP_FLAG_BY_INDEX_CLEAR:
                flagReg[opBit] <= 1'b0;
              `CSL_OP_BST:
                flagReg[`CSL_F_T] <= src[opBit];
              `CSL_OP_BLD:
                rf[opReg][opBit] <= flagReg[`CSL_F_T];
              `CSL_OP_SEC: flagReg[`CSL_F_C] <= 1'b1;
              `CSL_OP_CLC: flagReg[`CSL_F_C] <= 1'b0;
              `CSL_OP_SEN: flagReg[`CSL_F_N] <= 1'b1;
              `CSL_OP_CLN: flagReg[`CSL_F_N] <= 1'b0;
              `CSL_OP_SEZ: flagReg[`CSL_F_Z] <= 1'b1;
              `CSL_OP_CLZ: flagReg[`CSL_F_Z] <= 1'b0;
              `CSL_OP_SEI: flagReg[`CSL_F_I] <= 1'b1;
              `CSL_OP_CLI: flagReg[`CSL_F_I] <= 1'b0;
              default:
                flagReg <= flagReg;        // unknown code acts as a no-op
            endcase
          end
        S_FIN:
        begin
          // second cycle of every two-cycle form
          opDone <= 1'b1;
          state  <= S_IDLE;
        end
        S_CODE1:
          state <= S_CODE2;                // program memory answers one cycle late
        S_CODE2:
        begin
          rf[curReg] <= codeRdData;
          opDone     <= 1'b1;
          state      <= S_IDLE;
        end
        S_SPMW:
          if (spmDone)
          begin
            opDone <= 1'b1;
            state  <= S_IDLE;
          end
        default:
          state <= S_IDLE;
      endcase

      // software writes land last, so they win over a core write that cycle
      if (regWr)
      begin
        if (regAddr <= `CSL_A_RF_TOP)
          rf[regAddr[4:0]] <= regWrData;
        else if (regAddr == `CSL_A_FLAGS)
          flagReg <= regWrData;
        else if (regAddr == `CSL_A_PAGE)
          codePage <= regWrData;
        else if (regAddr == `CSL_A_SPL)
          stackPtr[7:0] <= regWrData;
        else if (regAddr == `CSL_A_SPH)
          stackPtr[15:8] <= regWrData;
      end

      // read data stands in the cycle after the read strobe only
      if (regRd)
      begin
        if (regAddr <= `CSL_A_RF_TOP)
          regRdData <= rf[regAddr[4:0]];
        else if (regAddr == `CSL_A_FLAGS)
          regRdData <= flagReg;
        else if (regAddr == `CSL_A_PAGE)
          regRdData <= codePage;
        else if (regAddr == `CSL_A_SPL)
          regRdData <= stackPtr[7:0];
        else if (regAddr == `CSL_A_SPH)
          regRdData <= stackPtr[15:8];
        else if (regAddr == `CSL_A_STAT)
          regRdData <= {7'h00, ~idle};
        else
          regRdData <= 8'h00;
      end
      else
        regRdData <= 8'h00;
    end
  end

endmodule

// [csl_mem_model.sv]
// data, i/o and program memory model facing the execution core
module csl_mem_model #(parameter int SPM_WAIT = 3) (
  input  logic        clk,
  input  logic        dataWrEn,
  input  logic [15:0] dataWrAddr,
  input  logic [7:0]  dataWrData,
  input  logic        dataRdEn,
  input  logic [15:0] dataRdAddr,
  output logic [7:0]  dataRdData,
  input  logic        ioWrEn,
  input  logic [5:0]  ioWrAddr,
  input  logic [7:0]  ioWrData,
  input  logic        ioRdEn,
  input  logic [5:0]  ioRdAddr,
  output logic [7:0]  ioRdData,
  input  logic        codeRdEn,
  input  logic [23:0] codeRdAddr,
  output logic [7:0]  codeRdData,
  input  logic        spmReq,
  input  logic [23:0] spmAddr,
  input  logic [15:0] spmData,
  output logic        spmDone
);
  logic [7:0]  dmem [0:65535];
  logic [7:0]  io [0:63];
  logic [7:0]  junk = 8'h00;
  logic [7:0]  codeByte;
  logic        codeLive = 1'b0;
  logic [3:0]  spmCnt = 4'h0;
  logic [23:0] spmAddrSeen;
  logic [15:0] spmDataSeen;
  // =====================================================================
  // read paths
  // unselected lines show a moving pattern so a stale value never matches
  assign dataRdData = dataRdEn ? dmem[dataRdAddr] : junk;
  assign ioRdData   = ioRdEn ? io[ioRdAddr] : junk;
  assign codeRdData = codeLive ? codeByte : junk;
  // writes land at the edge; a code byte answers one cycle after its request
  always @(posedge clk)
  begin
    junk <= junk + 8'h3B;
    if (dataWrEn)
      dmem[dataWrAddr] <= dataWrData;
    if (ioWrEn)
      io[ioWrAddr] <= ioWrData;
    codeLive <= codeRdEn;
    codeByte <= codeRdAddr[7:0] ^ codeRdAddr[15:8] ^ codeRdAddr[23:16] ^ 8'h5A;
  end
  // =====================================================================
  // self-programming ends a fixed time after the request
  always @(posedge clk)
  begin
    spmDone <= 1'b0;
    if (spmReq)
    begin
      spmCnt <= 4'(SPM_WAIT);
      spmAddrSeen <= spmAddr;
      spmDataSeen <= spmData;
    end
    else if (spmCnt != 4'h0)
    begin
      spmCnt <= spmCnt - 4'h1;
      spmDone <= (spmCnt == 4'h1);
    end
  end
endmodule

// [csl_core_asserts.sv]
// timing and data checks on the execution core ports
`include "csl_map.vh"
module csl_core_asserts (
  input logic        clk,
  input logic        rst_n,
  input logic        opStart,
  input logic [4:0]  opCode,
  input logic [2:0]  opBit,
  input logic [15:0] opAddr,
  input logic        opReady,
  input logic        opDone,
  input logic        dataWrEn,
  input logic [15:0] dataWrAddr,
  input logic        dataRdEn,
  input logic        ioWrEn,
  input logic [7:0]  ioWrData,
  input logic        ioRdEn,
  input logic [5:0]  ioRdAddr,
  input logic [7:0]  ioRdData,
  input logic        codeRdEn,
  input logic        spmReq,
  input logic        spmDone
);
  wire tk = opStart && opReady;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // operation timing
  property p_st;
    tk && opCode == `CSL_OP_ST |=> dataWrEn && !opReady ##1 opDone && opReady;
  endproperty
  property p_sts;
    tk && opCode == `CSL_OP_STS |=> dataWrEn && dataWrAddr == $past(opAddr) ##1 opDone;
  endproperty
  property p_code;
    tk && (opCode == `CSL_OP_LPM || opCode == `CSL_OP_EXTENDED_CODE_BYTE_READ) |=> codeRdEn && !opDone ##1 !opDone ##1 opDone;
  endproperty
  property p_push;
    tk && opCode == `CSL_OP_PUSH |=> dataWrEn && !opDone ##1 opDone;
  endproperty
  property p_pop;
    dataRdEn |-> tk ##1 !opDone ##1 opDone;
  endproperty
  property p_sbi;
    tk && opCode == `CSL_OP_SBI |-> ioRdEn && ioRdAddr == opAddr[5:0]
      ##1 ioWrEn && ioWrData == ($past(ioRdData) | (8'h01 << $past(opBit))) ##1 opDone;
  endproperty
  property p_cbi;
    tk && opCode == `CSL_OP_CBI |-> ioRdEn
      ##1 ioWrEn && ioWrData == ($past(ioRdData) & ~(8'h01 << $past(opBit))) ##1 opDone;
  endproperty
  property p_one;
    tk && opCode inside {`CSL_OP_IN, `CSL_OP_OUT, [`CSL_OP_LSL:`CSL_OP_CLI]} |=> opDone && opReady;
  endproperty
  property p_spm;
    spmDone && !opReady |=> opDone;
  endproperty
  a_st: assert property (p_st) else $error("store timing wrong");
  a_sts: assert property (p_sts) else $error("direct write wrong");
  a_code: assert property (p_code) else $error("code read timing wrong");
  a_push: assert property (p_push) else $error("stack save timing wrong");
  a_pop: assert property (p_pop) else $error("stack restore timing wrong");
  a_sbi: assert property (p_sbi) else $error("io bit set wrong");
  a_cbi: assert property (p_cbi) else $error("io bit clear wrong");
  a_one: assert property (p_one) else $error("single cycle op late");
  a_spm: assert property (p_spm) else $error("code write end late");
  c_spm: cover property (spmReq);
  c_pop: cover property (dataRdEn);
  c_io: cover property (ioWrEn ##1 opDone);
endmodule
bind csl_core csl_core_asserts chk (.clk, .rst_n, .opStart, .opCode, .opBit, .opAddr, .opReady, .opDone,
  .dataWrEn, .dataWrAddr, .dataRdEn, .ioWrEn, .ioWrData, .ioRdEn, .ioRdAddr, .ioRdData, .codeRdEn,
  .spmReq, .spmDone);

// [testbench.sv]
// self-checking bench for the execution core
`include "csl_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPM_WAIT = 3;
  logic        clk, rst_n, opStart, opReady, opDone, regWr, regRd;
  logic        dataWrEn, dataRdEn, ioWrEn, ioRdEn, codeRdEn, spmReq, spmDone;
  logic [4:0]  opCode, opReg;
  logic [1:0]  opPtr, opMode;
  logic [2:0]  opBit;
  logic [5:0]  opDisp, ioWrAddr, ioRdAddr;
  logic [15:0] opAddr, dataWrAddr, dataRdAddr, spmData;
  logic [7:0]  regAddr, regWrData, regRdData, dataWrData, dataRdData, ioWrData, ioRdData, codeRdData;
  logic [23:0] codeRdAddr, spmAddr;
  int          n_fail = 0;
  int          checks = 0;
  csl_core uut (.clk, .rst_n, .opStart, .opCode, .opReg, .opPtr, .opMode, .opBit, .opDisp, .opAddr,
    .opReady, .opDone, .dataWrEn, .dataWrAddr, .dataWrData, .dataRdEn, .dataRdAddr, .dataRdData, .ioWrEn,
    .ioWrAddr, .ioWrData, .ioRdEn, .ioRdAddr, .ioRdData, .codeRdEn, .codeRdAddr, .codeRdData, .spmReq,
    .spmAddr, .spmData, .spmDone, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
  csl_mem_model #(.SPM_WAIT(SPM_WAIT)) mem (.clk, .dataWrEn, .dataWrAddr, .dataWrData, .dataRdEn,
    .dataRdAddr, .dataRdData, .ioWrEn, .ioWrAddr, .ioWrData, .ioRdEn, .ioRdAddr, .ioRdData, .codeRdEn,
    .codeRdAddr, .codeRdData, .spmReq, .spmAddr, .spmData, .spmDone);
  // =====================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  // read one or two register bytes, low byte first
  task automatic ex(input logic [7:0] a, input logic [15:0] e, input int w);
    logic [7:0] lo;
    logic [7:0] hi;
    hi = 8'h00;
    rd(a, lo);
    if (w == 2)
      rd(a + 8'h01, hi);
    chk("register", {8'h00, e}, {8'h00, hi, lo});
  endtask
  // issue one operation and count the cycles to its completion pulse
  task automatic op(input logic [4:0] c, input logic [4:0] r, input logic [1:0] p, input logic [1:0] m,
                    input logic [2:0] b, input logic [15:0] a, input int cyc);
    int n;
    @(posedge clk);
    opStart <= 1'b1;
    opCode <= c;
    opReg <= r;
    opPtr <= p;
    opMode <= m;
    opBit <= b;
    opAddr <= a;
    opDisp <= a[5:0];
    @(posedge clk);
    opStart <= 1'b0;
    n = 1;
    #1;
    while (opDone !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("cycles", 24'(cyc), 24'(n));
  endtask
  function automatic logic [7:0] cb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction
  // =====================================================================
  // scenarios
  task automatic t_reset;
    ex(`CSL_A_FLAGS, 16'h0000, 1);
    ex(`CSL_A_SPL, `CSL_SP_RESET, 2);
    ex(`CSL_A_STAT, 16'h0000, 1);
    wr(8'h30, 8'h55);
    ex(8'h30, 16'h0000, 1);
  endtask
  task automatic t_store;
    wr(8'h05, 8'h3C);
    wr16(`CSL_YL, 16'h0100);
    op(`CSL_OP_ST, 5, `CSL_PTR_Y, `CSL_MODE_POSTI, 0, 0, 2);
    chk("mem", 8'h3C, mem.dmem[16'h0100]);
    ex(`CSL_YL, 16'h0101, 2);
    wr(8'h05, 8'hC3);
    wr16(`CSL_XL, 16'h0100);
    op(`CSL_OP_ST, 5, `CSL_PTR_X, `CSL_MODE_PRED, 0, 0, 2);
    chk("mem", 8'hC3, mem.dmem[16'h00FF]);
    ex(`CSL_XL, 16'h00FF, 2);
    wr16(`CSL_ZL, 16'h0200);
    op(`CSL_OP_ST, 5, `CSL_PTR_Z, `CSL_MODE_DISP, 0, 16'h003F, 2);
    chk("mem", 8'hC3, mem.dmem[16'h023F]);
    ex(`CSL_ZL, 16'h0200, 2);
    op(`CSL_OP_STS, 5, 0, 0, 0, 16'hFFFF, 2);
    chk("mem", 8'hC3, mem.dmem[16'hFFFF]);
    ex(`CSL_A_FLAGS, 16'h0000, 1);
  endtask
  task automatic t_code;
    wr16(`CSL_ZL, 16'hFFFF);
    wr(`CSL_A_PAGE, 8'h02);
    op(`CSL_OP_EXTENDED_CODE_BYTE_READ, 7, 0, `CSL_MODE_POSTI, 0, 0, 3);
    ex(8'h07, cb(24'h02FFFF), 1);
    ex(`CSL_ZL, 16'h0000, 2);
    ex(`CSL_A_PAGE, 16'h0003, 1);
    wr16(`CSL_ZL, 16'h12FF);
    op(`CSL_OP_LPM, 9, 0, `CSL_MODE_POSTI, 0, 0, 3);
    ex(8'h09, cb(24'h0012FF), 1);
    op(`CSL_OP_LPM, 0, 0, `CSL_MODE_PLAIN, 0, 0, 3);
    ex(`CSL_R0, cb(24'h001300), 1);
    ex(`CSL_ZL, 16'h1300, 2);
  endtask
  task automatic t_stack;
    wr16(`CSL_A_SPL, 16'h1000);
    wr(8'h09, 8'h77);
    op(`CSL_OP_PUSH, 9, 0, 0, 0, 0, 2);
    chk("mem", 8'h77, mem.dmem[16'h1000]);
    ex(`CSL_A_SPL, 16'h0FFF, 2);
    op(`CSL_OP_POP, 10, 0, 0, 0, 0, 2);
    ex(8'h0A, 16'h0077, 1);
    ex(`CSL_A_SPL, 16'h1000, 2);
  endtask
  task automatic t_io;
    wr(8'h0B, 8'hA5);
    op(`CSL_OP_OUT, 11, 0, 0, 0, 16'h001F, 1);
    op(`CSL_OP_IN, 12, 0, 0, 0, 16'h001F, 1);
    ex(8'h0C, 16'h00A5, 1);
    op(`CSL_OP_SBI, 0, 0, 0, 1, 16'h001F, 2);
    chk("io", 8'hA7, mem.io[31]);
    op(`CSL_OP_CBI, 0, 0, 0, 7, 16'h001F, 2);
    chk("io", 8'h27, mem.io[31]);
  endtask
  // expected result and flags of a shift or swap
  function automatic logic [15:0] shx(input logic [4:0] c, input logic [7:0] d, input logic [7:0] f);
    logic [7:0] r;
    logic       co;
    co = d[7];
    r = {d[6:0], 1'b0};
    case (c)
      `CSL_OP_LSR: {r, co} = {1'b0, d};
      `CSL_OP_ROL: r = {d[6:0], f[0]};
      `CSL_OP_ROR: {r, co} = {f[0], d};
      `CSL_OP_ASR: {r, co} = {d[7], d};
      `CSL_OP_SWAP: return {d[3:0], d[7:4], f};
      default: ;
    endcase
    return {r, f[7:4], r[7] ^ co, r[7], r == 8'h00, co};
  endfunction
  task automatic t_shift;
    logic [4:0]  sc [6] = '{`CSL_OP_LSL, `CSL_OP_LSR, `CSL_OP_ROL, `CSL_OP_ROR, `CSL_OP_ASR, `CSL_OP_SWAP};
    logic [15:0] e;
    foreach (sc[i])
      for (int k = 0; k < 2; k++)
      begin
        e = shx(sc[i], k ? 8'h80 : 8'h81, k ? 8'hC0 : 8'hC1);
        wr(8'h0D, k ? 8'h80 : 8'h81);
        wr(`CSL_A_FLAGS, k ? 8'hC0 : 8'hC1);
        op(sc[i], 13, 0, 0, 0, 0, 1);
        ex(8'h0D, {8'h00, e[15:8]}, 1);
        ex(`CSL_A_FLAGS, {8'h00, e[7:0]}, 1);
      end
  endtask
  task automatic t_flags;
    logic [2:0] fb [4] = '{`CSL_F_C, `CSL_F_N, `CSL_F_Z, `CSL_F_I};
    logic [7:0] m;
    for (int i = 0; i < 16; i++)
    begin
      wr(`CSL_A_FLAGS, i[0] ? 8'hFF : 8'h00);
      if (i < 8)
        op(5'(`CSL_OP_SEC + i), 0, 0, 0, 0, 0, 1);
      else
        op(i[0] ? `CSL_OP_FLAG_BY_INDEX_CLEAR : `CSL_OP_FLAG_BY_INDEX_SET, 0, 0, 0, 3'(i / 2), 0, 1);
      m = i[0] ? ~(8'h01 << (i < 8 ? fb[i / 2] : 3'(i / 2))) : (8'h01 << (i < 8 ? fb[i / 2] : 3'(i / 2)));
      ex(`CSL_A_FLAGS, {8'h00, m}, 1);
    end
  endtask
  task automatic t_bits;
    wr(8'h0E, 8'h20);
    wr(`CSL_A_FLAGS, 8'h01);
    op(`CSL_OP_BST, 14, 0, 0, 5, 0, 1);
    ex(`CSL_A_FLAGS, 16'h0041, 1);
    wr(8'h0F, 8'h80);
    op(`CSL_OP_BLD, 15, 0, 0, 0, 0, 1);
    ex(8'h0F, 16'h0081, 1);
    ex(`CSL_A_FLAGS, 16'h0041, 1);
  endtask
  task automatic t_spm;
    wr16(`CSL_R0, 16'h1234);
    wr16(`CSL_ZL, 16'h0040);
    wr(`CSL_A_PAGE, 8'h01);
    op(`CSL_OP_SPM, 0, 0, 0, 0, 0, SPM_WAIT + 3);
    chk("spm addr", 24'h010040, mem.spmAddrSeen);
    chk("spm data", 24'h001234, {8'h00, mem.spmDataSeen});
  endtask
  // =====================================================================
  // verdict, clock, watchdog and main sequence
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hung handshake is cut short well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, opStart, regWr, regRd, opCode, opReg, opPtr, opMode, opBit, opDisp} = '0;
    {opAddr, regAddr, regWrData} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_store();
    t_code();
    t_stack();
    t_io();
    t_shift();
    t_flags();
    t_bits();
    t_spm();
    tally_and_finish();
  end
endmodule
